/* common/fhe_pkg.sv */
/*
  Constants for the half-full / echo-read FIFO block: register map,
  control and interrupt field positions, reset values, synchroniser lanes.
  Assumes a 32-bit APB master and byte addresses on an 8-bit paddr.
*/
package fhe_pkg;
  // geometry: words of 18 bits for the smallest variant
  localparam int DEPTH_X18 = 2048;
  localparam int OFFSET_W = 20;
  localparam int ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_OFFSET = 8'h10;
  // control register fields
  localparam int CTRL_FALL_THROUGH_MODE = 0;
  localparam int CTRL_IN_X9 = 1;
  localparam int CTRL_OUT_X9 = 2;
  localparam int CTRL_BYTE_LE = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // status register fields
  localparam int STAT_HF = 31;
  localparam int STAT_EMPTY = 30;
  // interrupt bits
  localparam int IRQ_HF_SET = 0;
  localparam int IRQ_HF_CLR = 1;
  localparam int IRQ_WR_REJ = 2;
  localparam int IRQ_RD_REJ = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_RST = 4'h0;
  // synchroniser lanes for pin inputs
  localparam int S_WCLK = 0;
  localparam int S_WEN = 1;
  localparam int S_WCS = 2;
  localparam int S_RCLK = 3;
  localparam int S_REN = 4;
  localparam int S_RCS = 5;
  localparam int S_SCLK = 6;
  localparam int S_SEN = 7;
  localparam int S_SIN = 8;
  localparam int S_MRST = 9;
  localparam int S_PRST = 10;
  localparam int S_W = 11;
  localparam logic [10:0] SYNC_RST = 11'h6B6;
endpackage

/* testbench/fhe_pins_model.sv */
/*
  Write and read parties on slow pin clocks, plus the serial offset loader.
  Assumes pclk runs at 100 ns; write and serial clock periods are 800 ns, the read clock
  period is 1000 ns, and each only runs while its task is in progress.
*/
module fhe_pins_model (
  input wire logic pclk,
  output logic wr_clk,
  output logic wr_enable_n,
  output logic wr_chip_select_n,
  output logic [17:0] data_in,
  output logic rd_clk,
  output logic rd_enable_n,
  output logic rd_chip_select_n,
  output logic serial_load_clk,
  output logic serial_load_enable_n,
  output logic serial_in,
  input wire logic echo_rd_clk,
  input wire logic echo_rd_enable_n,
  input wire logic [17:0] data_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle levels: clocks low, enables inactive
  initial begin
    wr_clk = 1'b0;
    rd_clk = 1'b0;
    serial_load_clk = 1'b0;
    wr_enable_n = 1'b1;
    wr_chip_select_n = 1'b1;
    rd_enable_n = 1'b1;
    rd_chip_select_n = 1'b1;
    serial_load_enable_n = 1'b1;
    serial_in = 1'b0;
    data_in = 18'h00000;
  end

  // one write clock period; data held 2 pclk before and 8 pclk after the rise
  task automatic wr(input logic [17:0] d);
    @(posedge pclk);
    data_in <= d;
    wr_enable_n <= 1'b0;
    wr_chip_select_n <= 1'b0;
    repeat (2) @(posedge pclk);
    wr_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    wr_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    wr_enable_n <= 1'b1;
    wr_chip_select_n <= 1'b1;
    data_in <= ~d; // released bus does not keep the old word
  endtask

  // one read clock period; samples echo clock in each half, echo enable and data in the high half
  task automatic rd(input logic en_n, output logic e, output logic [17:0] q,
                    output logic [1:0] ec);
    @(posedge pclk);
    rd_enable_n <= en_n;
    rd_chip_select_n <= en_n;
    repeat (2) @(posedge pclk);
    rd_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    ec[1] = echo_rd_clk;
    e = echo_rd_enable_n;
    q = data_out;
    @(posedge pclk);
    rd_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    ec[0] = echo_rd_clk;
    @(posedge pclk);
    rd_enable_n <= 1'b1;
    rd_chip_select_n <= 1'b1;
  endtask

  // one serial bit, enable held low across the rising edge
  task automatic sbit(input logic b);
    @(posedge pclk);
    serial_in <= b;
    serial_load_enable_n <= 1'b0;
    repeat (2) @(posedge pclk);
    serial_load_clk <= 1'b1;
    repeat (4) @(posedge pclk);
    serial_load_clk <= 1'b0;
    repeat (4) @(posedge pclk);
    serial_load_enable_n <= 1'b1;
    serial_in <= ~b;
  endtask
endmodule

/* testbench/tb.sv */
/*
  Self-checking bench for the half-full / echo-read FIFO block.
  Assumes fhe_pkg register map and a depth of 16 words for short runs.
*/
`define CHK(nm, ex, got) begin \
  checked++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s exp %0h got %0h", nm, ex, got); \
  end \
end

module tb;
  import fhe_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEP = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, irq, half_full_n, echo_rd_clk, echo_rd_enable_n;
  logic wr_clk, wr_enable_n, wr_chip_select_n, rd_clk, rd_enable_n, rd_chip_select_n;
  logic serial_load_clk, serial_load_enable_n, serial_in;
  logic master_reset_n = 1'b1;
  logic partial_reset_n = 1'b1;
  logic [17:0] data_in, data_out;
  int error_cnt = 0;
  int checked = 0;

  fhe_fifo_half_echo #(.DEPTH(DEP)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wr_clk(wr_clk), .wr_enable_n(wr_enable_n),
    .wr_chip_select_n(wr_chip_select_n), .data_in(data_in), .rd_clk(rd_clk),
    .rd_enable_n(rd_enable_n), .rd_chip_select_n(rd_chip_select_n),
    .serial_load_clk(serial_load_clk), .serial_load_enable_n(serial_load_enable_n),
    .serial_in(serial_in), .master_reset_n(master_reset_n),
    .partial_reset_n(partial_reset_n), .data_out(data_out), .half_full_n(half_full_n),
    .echo_rd_clk(echo_rd_clk), .echo_rd_enable_n(echo_rd_enable_n), .irq(irq));

  fhe_pins_model p (.pclk(pclk), .wr_clk(wr_clk), .wr_enable_n(wr_enable_n),
    .wr_chip_select_n(wr_chip_select_n), .data_in(data_in), .rd_clk(rd_clk),
    .rd_enable_n(rd_enable_n), .rd_chip_select_n(rd_chip_select_n),
    .serial_load_clk(serial_load_clk), .serial_load_enable_n(serial_load_enable_n),
    .serial_in(serial_in), .echo_rd_clk(echo_rd_clk),
    .echo_rd_enable_n(echo_rd_enable_n), .data_out(data_out));

  // 10 MHz system clock
  always #50 pclk = ~pclk;

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) `CHK("pready", 1'b1, pready)
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // read and compare data and error response
  task automatic rdc(input logic [7:0] a, input logic [31:0] ex, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK("prdata", ex, q)
    `CHK("pslverr", ee, e)
  endtask

  // let pin-side updates land, then sample mid-cycle
  task automatic settle();
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic pin_reset(input logic part);
    @(posedge pclk);
    if (part) partial_reset_n <= 1'b0;
    else master_reset_n <= 1'b0;
    repeat (8) @(posedge pclk);
    master_reset_n <= 1'b1;
    partial_reset_n <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  function automatic logic [17:0] word(input int i);
    return 18'(i * 32'h0001_2345 + 32'h0000_00A7);
  endfunction

  // n word writes, flag must stay high through write number lim
  task automatic fill(input int n, input int lim);
    for (int i = 1; i <= n; i++) begin
      p.wr(word(i));
      settle();
      `CHK("half_full_n", logic'(i <= lim), half_full_n)
    end
  endtask

  task automatic t_regs();
    `CHK("reset flag", 1'b1, half_full_n)
    `CHK("reset echo", 1'b1, echo_rd_enable_n)
    `CHK("reset irq", 1'b0, irq)
    rdc(ADDR_CTRL, 32'h0000_0000, 1'b0);
    rdc(ADDR_STAT, 32'h4000_0000, 1'b0);
    rdc(8'h20, 32'h0000_0000, 1'b1);
    wrr(ADDR_CTRL, 32'h0000_000F);
    rdc(ADDR_CTRL, 32'h0000_000F, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_std();
    logic e;
    logic [17:0] d;
    logic [1:0] ec;
    wrr(ADDR_CTRL, 32'h0000_0000);
    pin_reset(1'b0);
    wrr(ADDR_IRQ_MASK, 32'h0000_0003);
    fill(DEP / 2 + 1, DEP / 2);
    rdc(ADDR_STAT, 32'h8000_0012, 1'b0);
    `CHK("irq set", 1'b1, irq)
    rdc(ADDR_IRQ_STAT, 32'h0000_0001, 1'b0);
    wrr(ADDR_IRQ_STAT, 32'h0000_0001);
    settle();
    `CHK("irq clr", 1'b0, irq)
    p.rd(1'b0, e, d, ec);
    settle();
    `CHK("echo_rd_enable_n", 1'b0, e)
    `CHK("data_out", word(1), d)
    `CHK("half_full_n", 1'b1, half_full_n)
    `CHK("irq rose", 1'b1, irq)
    wrr(ADDR_IRQ_MASK, 32'h0000_0000);
    settle();
    `CHK("irq masked", 1'b0, irq)
    $display("test standard flag done");
  endtask

  task automatic t_fall();
    wrr(ADDR_CTRL, 32'h0000_0001);
    pin_reset(1'b1);
    fill(DEP / 2 + 2, DEP / 2 + 1);
    wrr(ADDR_CTRL, 32'h0000_0006);
    pin_reset(1'b1);
    fill(DEP + 1, DEP);
    wrr(ADDR_CTRL, 32'h0000_0007);
    pin_reset(1'b1);
    fill(DEP + 2, DEP + 1);
    $display("test fall-through flag done");
  endtask

  task automatic t_echo();
    logic e;
    logic [17:0] d;
    logic [1:0] ec;
    pin_reset(1'b0);
    wrr(ADDR_IRQ_STAT, 32'h0000_000F);
    p.rd(1'b1, e, d, ec);
    `CHK("echo_rd_clk", 2'b10, ec)
    `CHK("echo idle", 1'b1, e)
    p.rd(1'b0, e, d, ec);
    `CHK("echo empty", 1'b1, e)
    `CHK("echo_rd_clk", 2'b10, ec)
    rdc(ADDR_IRQ_STAT, 32'h0000_0008, 1'b0);
    $display("test echo done");
  endtask

  // x18 in, x9 out, both byte orders
  task automatic t_bytes();
    logic e;
    logic [17:0] d;
    logic [1:0] ec;
    for (int le = 0; le < 2; le++) begin
      wrr(ADDR_CTRL, le ? 32'h0000_000C : 32'h0000_0004);
      pin_reset(1'b0);
      p.wr(word(5));
      p.rd(1'b0, e, d, ec);
      `CHK("byte 1", {9'h000, le ? word(5) : word(5) >> 9} & 18'h001FF, d)
      p.rd(1'b0, e, d, ec);
      `CHK("byte 2", {9'h000, le ? word(5) >> 9 : word(5)} & 18'h001FF, d)
      // x9 in, x18 out: two bytes assembled into one word
      wrr(ADDR_CTRL, le ? 32'h0000_000A : 32'h0000_0002);
      pin_reset(1'b0);
      p.wr(18'h000A5);
      p.wr(18'h0015A);
      p.rd(1'b0, e, d, ec);
      `CHK("word", le ? 18'h2B4A5 : 18'h14B5A, d)
      `CHK("echo word", 1'b0, e)
    end
    $display("test byte order done");
  endtask

  task automatic t_serial();
    pin_reset(1'b0);
    p.sbit(1'b1);
    p.sbit(1'b0);
    p.sbit(1'b1);
    p.sbit(1'b1);
    rdc(ADDR_OFFSET, 32'h0000_000B, 1'b0);
    pin_reset(1'b1);
    rdc(ADDR_OFFSET, 32'h0000_000B, 1'b0);
    $display("test serial done");
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_std();
    t_fall();
    t_echo();
    t_bytes();
    t_serial();
    final_report();
  end

  // watchdog
  initial begin
    #2000000;
    error_cnt++;
    final_report();
  end
endmodule

/* verilog/fhe_fifo_half_echo.sv */
/*
  Dual-clock byte FIFO with half-full flag, echoed read clock and
  read enable, serial offset load and 18/9-bit bus matching.
  Assumes write, read and serial clocks far slower than pclk (>= 4x), so
  every pin is taken through two flip-flops and the edges of the three clock pins found on pclk.
*/
// Design decisions made here: the APB register port and the placing of the registers.
// Notes on behaviour
// - write edge lifting count above half depth drives half_full_n low
// - read edge bringing count to half depth or less drives it high
// - standard mode, no reads: flag falls after D/2 plus one writes
// - with any 18-bit port, depth is a power of two, 2048 to 524288
// - with both ports 9-bit, depth doubles, 4096 to 1048576
// - fall-through mode, no reads: flag falls after D/2 plus two writes
// - half_full_n is set by writes and cleared by reads, so asynchronous
// - echo_rd_clk follows rd_clk always, whatever enable and select do
// - valid read edge with data present drives echo_rd_enable_n low
// - serial_in is shifted in on serial clock edges with enable low
// - data_out uses bits 17..0 for 18-bit output, bits 8..0 for 9-bit
module fhe_fifo_half_echo #(
  parameter int DEPTH = fhe_pkg::DEPTH_X18,
  parameter int OFFSET_W = fhe_pkg::OFFSET_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [fhe_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wr_clk,
  input wire logic wr_enable_n,
  input wire logic wr_chip_select_n,
  input wire logic [17:0] data_in,
  input wire logic rd_clk,
  input wire logic rd_enable_n,
  input wire logic rd_chip_select_n,
  input wire logic serial_load_clk,
  input wire logic serial_load_enable_n,
  input wire logic serial_in,
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  output logic [17:0] data_out,
  output logic half_full_n,
  output logic echo_rd_clk,
  output logic echo_rd_enable_n,
  output logic irq
);
  import fhe_pkg::*;

  // byte capacity is the same for 18-bit and all-9-bit use
  localparam int CAP = 2 * DEPTH;
  localparam int AW = $clog2(CAP);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] HALF_B = PW'(DEPTH);

  // pin synchronisers: meta stage feeds only the second stage
  logic [S_W-1:0] meta_reg;
  logic [S_W-1:0] sync_reg;
  logic [S_W-1:0] prev_reg;
  logic [17:0] din_meta_reg;
  logic [17:0] din_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= SYNC_RST;
      sync_reg <= SYNC_RST;
      prev_reg <= SYNC_RST;
      din_meta_reg <= 18'h00000;
      din_sync_reg <= 18'h00000;
    end else begin
      meta_reg <= {partial_reset_n, master_reset_n, serial_in, serial_load_enable_n,
                   serial_load_clk, rd_chip_select_n, rd_enable_n, rd_clk,
                   wr_chip_select_n, wr_enable_n, wr_clk};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      din_meta_reg <= data_in;
      din_sync_reg <= din_meta_reg;
    end
  end

  // rising edges of the three slow clocks, seen on pclk
  logic wr_rise;
  logic rd_rise;
  logic sl_rise;
  logic fifo_clr;
  logic offs_clr;
  assign wr_rise = sync_reg[S_WCLK] & ~prev_reg[S_WCLK];
  assign rd_rise = sync_reg[S_RCLK] & ~prev_reg[S_RCLK];
  assign sl_rise = sync_reg[S_SCLK] & ~prev_reg[S_SCLK];
  assign fifo_clr = ~sync_reg[S_MRST] | ~sync_reg[S_PRST];
  assign offs_clr = ~sync_reg[S_MRST];

  // state
  logic [8:0] mem [CAP];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic hf_n_reg, hf_n_next;
  logic echo_rd_enable_n_n_reg, echo_rd_enable_n_n_next;
  logic echo_clk_reg;
  logic [17:0] dout_reg, dout_next;
  logic [OFFSET_W-1:0] offs_reg, offs_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next, pslverr_reg, pslverr_next;

  // fifo datapath terms
  logic [PW-1:0] cnt, cnt_new, wunit, runit, thr;
  logic wr_req, rd_req, wr_ok, rd_ok;
  logic [8:0] b0, b1, w_first, w_second;
  logic in_x9, out_x9, le;

  always_comb begin
    in_x9 = ctrl_reg[CTRL_IN_X9];
    out_x9 = ctrl_reg[CTRL_OUT_X9];
    le = ctrl_reg[CTRL_BYTE_LE];
    wunit = in_x9 ? PW'(1) : PW'(2);
    runit = out_x9 ? PW'(1) : PW'(2);
    cnt = wp_reg - rp_reg;
    // one extra unit for the output stage in fall-through mode
    thr = HALF_B;
    if (ctrl_reg[CTRL_FALL_THROUGH_MODE]) begin
      thr = HALF_B + ((in_x9 & out_x9) ? PW'(1) : PW'(2));
    end
    wr_req = wr_rise & ~sync_reg[S_WEN] & ~sync_reg[S_WCS];
    rd_req = rd_rise & ~sync_reg[S_REN] & ~sync_reg[S_RCS];
    wr_ok = wr_req & ~fifo_clr & ((cnt + wunit) <= PW'(CAP));
    rd_ok = rd_req & ~fifo_clr & (cnt >= runit);
    // split an 18-bit word into bytes, first byte by order select
    w_first = in_x9 ? din_sync_reg[8:0] : (le ? din_sync_reg[8:0] : din_sync_reg[17:9]);
    w_second = le ? din_sync_reg[17:9] : din_sync_reg[8:0];
    b0 = mem[rp_reg[AW-1:0]];
    b1 = mem[AW'(rp_reg[AW-1:0] + AW'(1))];
  end

  // byte store, one or two bytes per write edge
  always_ff @(posedge pclk) begin
    if (wr_ok) begin
      mem[wp_reg[AW-1:0]] <= w_first;
      if (!in_x9) begin
        mem[AW'(wp_reg[AW-1:0] + AW'(1))] <= w_second;
      end
    end
  end

  // pointers, half-full flag, echo enable, output data
  always_comb begin
    wp_next = wp_reg;
    rp_next = rp_reg;
    hf_n_next = hf_n_reg;
    echo_rd_enable_n_n_next = echo_rd_enable_n_n_reg;
    dout_next = dout_reg;
    if (wr_ok) begin
      wp_next = wp_reg + wunit;
    end
    if (rd_ok) begin
      rp_next = rp_reg + runit;
      // narrow output sits in the low bits
      if (out_x9) begin
        dout_next = {9'h000, b0};
      end else if (le) begin
        dout_next = {b1, b0};
      end else begin
        dout_next = {b0, b1};
      end
    end
    cnt_new = wp_next - rp_next;
    // flag set by the write side and cleared by the read side
    if (wr_ok && cnt_new > thr) begin
      hf_n_next = 1'b0;
    end else if (rd_ok && cnt_new <= thr) begin
      hf_n_next = 1'b1;
    end
    // echo enable held for the whole read-clock cycle
    if (rd_rise) begin
      echo_rd_enable_n_n_next = ~rd_ok;
    end
    if (fifo_clr) begin
      wp_next = '0;
      rp_next = '0;
      hf_n_next = 1'b1;
      echo_rd_enable_n_n_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_reg <= '0;
      rp_reg <= '0;
      hf_n_reg <= 1'b1;
      echo_rd_enable_n_n_reg <= 1'b1;
      echo_clk_reg <= 1'b0;
      dout_reg <= 18'h00000;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      hf_n_reg <= hf_n_next;
      echo_rd_enable_n_n_reg <= echo_rd_enable_n_n_next;
      echo_clk_reg <= sync_reg[S_RCLK]; // free-running copy
      dout_reg <= dout_next;
    end
  end

  // serial offset shift register and interrupt status
  logic apb_wr;
  logic [IRQ_W-1:0] ev;
  assign apb_wr = psel & penable & pready_reg & pwrite;
  assign ev = {rd_req & ~rd_ok & ~fifo_clr, wr_req & ~wr_ok & ~fifo_clr,
               ~hf_n_reg & hf_n_next, hf_n_reg & ~hf_n_next}; // bit0 flag fell, bit1 rose

  always_comb begin
    offs_next = offs_reg;
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    if (sl_rise && !sync_reg[S_SEN]) begin
      offs_next = {offs_reg[OFFSET_W-2:0], sync_reg[S_SIN]};
    end
    if (offs_clr) begin
      offs_next = '0;
    end
    if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_next = pwdata[CTRL_W-1:0];
    end
    if (apb_wr && paddr == ADDR_IRQ_MASK) begin
      imask_next = pwdata[IRQ_W-1:0];
    end
    if (apb_wr && paddr == ADDR_IRQ_STAT) begin
      ist_next = ist_reg & ~pwdata[IRQ_W-1:0];
    end
    ist_next = ist_next | ev; // a new event beats a same-cycle clear
    irq_next = |(ist_next & imask_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offs_reg <= '0;
      ctrl_reg <= CTRL_RST;
      imask_reg <= IRQ_RST;
      ist_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      offs_reg <= offs_next;
      ctrl_reg <= ctrl_next;
      imask_reg <= imask_next;
      ist_reg <= ist_next;
      irq_reg <= irq_next;
    end
  end

  // apb answer prepared in the setup cycle, ready in the access cycle
  always_comb begin
    pready_next = psel & ~penable;
    pslverr_next = 1'b0;
    prdata_next = 32'h00000000;
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CTRL: prdata_next = 32'(ctrl_reg);
        ADDR_STAT: begin
          prdata_next = 32'(cnt);
          prdata_next[STAT_HF] = ~hf_n_reg;
          prdata_next[STAT_EMPTY] = (cnt == '0);
        end
        ADDR_IRQ_STAT: prdata_next = 32'(ist_reg);
        ADDR_IRQ_MASK: prdata_next = 32'(imask_reg);
        ADDR_OFFSET: prdata_next = 32'(offs_reg);
        default: pslverr_next = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign data_out = dout_reg;
  assign half_full_n = hf_n_reg;
  assign echo_rd_clk = echo_clk_reg;
  assign echo_rd_enable_n = echo_rd_enable_n_n_reg;
  assign irq = irq_reg;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_valid_read;
    rd_rise && rd_ok;
  endsequence

  property p_hf_set;
    wr_ok && !fifo_clr && cnt_new > thr |=> !half_full_n;
  endproperty
  a_hf_set: assert property (p_hf_set) else $error("half full not set");

  property p_hf_clr;
    rd_ok && !wr_ok && !fifo_clr && cnt_new <= thr |=> half_full_n;
  endproperty
  a_hf_clr: assert property (p_hf_clr) else $error("half full not cleared");

  property p_hf_fall_cause;
    $fell(half_full_n) |-> $past(wr_ok);
  endproperty
  a_hf_fall_cause: assert property (p_hf_fall_cause) else $error("flag fell without write");

  property p_hf_rise_cause;
    $rose(half_full_n) |-> $past(rd_ok) || $past(fifo_clr);
  endproperty
  a_hf_rise_cause: assert property (p_hf_rise_cause) else $error("flag rose without read");

  property p_echo_clk;
    echo_rd_clk == $past(rd_clk, 3);
  endproperty
  a_echo_clk: assert property (p_echo_clk) else $error("echo clock lost");

  property p_echo_rd_enable_n_low;
    s_valid_read and !fifo_clr |=> !echo_rd_enable_n ##1 (!echo_rd_enable_n || rd_rise);
  endproperty
  a_echo_rd_enable_n_low: assert property (p_echo_rd_enable_n_low) else $error("echo enable not low");

  property p_echo_rd_enable_n_high;
    rd_rise && !rd_ok |=> echo_rd_enable_n;
  endproperty
  a_echo_rd_enable_n_high: assert property (p_echo_rd_enable_n_high) else $error("echo enable low");

  property p_serial;
    sl_rise && !sync_reg[S_SEN] && !offs_clr |=> offs_reg[0] == $past(sync_reg[S_SIN]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit missed");

  property p_dout9;
    s_valid_read and out_x9 |=> data_out[17:9] == 9'h000;
  endproperty
  a_dout9: assert property (p_dout9) else $error("upper output bits set");
endmodule
